// file: include/pims_regs.svh
// Purpose: register offsets, field positions, reset values, timing counts
// Assumes: management register addresses are 5 bits wide
// Notes: definitions only
`ifndef PIMS_REGS_SVH
`define PIMS_REGS_SVH

`define PIMS_OFS_MASK 5'h18
`define PIMS_OFS_STAT 5'h19
`define PIMS_OFS_COND 5'h1a

`define PIMS_RST_MASK 16'h0000
`define PIMS_RST_STAT 16'h0000
`define PIMS_RST_FAULT 2'h0

`define PIMS_BIT_PIN_EN 0
`define PIMS_BIT_PEND 0
`define PIMS_BIT_SYNC_LOST 9
`define PIMS_EV_LSB 1
`define PIMS_EV_MSB 10
`define PIMS_BIT_STANDBY 15
`define PIMS_BIT_FAULT_MSB 14
`define PIMS_BIT_FAULT_LSB 13
`define PIMS_BIT_AN_DONE 12

`define PIMS_PREAMBLE_ONES 6'h20
`define PIMS_HDR_LAST 5'h0b
`define PIMS_DATA_LAST 5'h0f
`define PIMS_OP_RD 2'h2
`define PIMS_OP_WR 2'h1

`endif

// file: include/pims_pkg.sv
// Purpose: shared types of the interrupt mask and status block
// Assumes: constants live in pims_regs.svh
// Notes: none
package pims_pkg;

  typedef enum logic [2:0] {
    PIMS_HUNT,
    PIMS_START,
    PIMS_HDR,
    PIMS_TA,
    PIMS_DATA
  } pims_frame_e;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pims_req_s;

endpackage : pims_pkg

// file: design/pims_mdio.sv
// Purpose: serial management frame engine for the status block
// Assumes: mdc and mdio come from pins and are sampled by the local clock
// Notes: reads request data at header end, drives turnaround and data
`timescale 1ns/100ps
`default_nettype none
`include "pims_regs.svh"

module pims_mdio
  import pims_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input wire logic clk,             // local clock
  input wire logic srst,            // sync reset, high
  input wire logic mdc_raw,         // management clock pin
  input wire logic mdio_raw,        // management data pin in
  input wire logic suppress,        // preamble suppression active
  input wire logic [15:0] rdata,    // read data, valid after rd
  output var pims_req_s req,        // register request
  output logic mdio_out,            // data pin out
  output logic mdio_oe,             // data pin enable
  output logic sync_lost            // one-cycle loss of framing
);

  logic mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2;
  logic rise, bit_in, synced, is_rd, own;
  logic [5:0] ones;
  logic [4:0] bitcnt;
  logic [15:0] sh;
  logic [11:0] hdr;
  pims_frame_e state;

  // ***************
  // pin synchronisers
  // ***************
  always_ff @(posedge clk) begin
    mdc_s1 <= mdc_raw;
    mdc_s2 <= mdc_s1;
    mdc_s3 <= mdc_s2;
    mdio_s1 <= mdio_raw;
    mdio_s2 <= mdio_s1;
  end

  assign rise = mdc_s2 & ~mdc_s3;
  assign bit_in = mdio_s2;
  assign hdr = {sh[10:0], bit_in};

  // ***************
  // frame sequencer
  // ***************
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= PIMS_HUNT;
      ones <= 6'h00;
      bitcnt <= 5'h00;
      sh <= 16'h0000;
      synced <= 1'b0;
      is_rd <= 1'b0;
      own <= 1'b0;
      req <= '0;
      mdio_out <= 1'b1;
      mdio_oe <= 1'b0;
      sync_lost <= 1'b0;
    end else begin
      req.rd <= 1'b0;
      req.wr <= 1'b0;
      sync_lost <= 1'b0;
      if (rise) begin
        unique case (state)
          PIMS_HUNT: begin
            if (bit_in) begin
              if (ones != `PIMS_PREAMBLE_ONES) ones <= ones + 6'h01;
            end else begin
              ones <= 6'h00;
              // full preamble always resyncs, short one only with suppression active while in sync
              if (ones == `PIMS_PREAMBLE_ONES || (suppress && synced)) begin // [R7]
                state <= PIMS_START;
                synced <= 1'b1;
              end
            end
          end
          PIMS_START: begin
            bitcnt <= 5'h00;
            if (bit_in) begin
              state <= PIMS_HDR;
            end else begin
              state <= PIMS_HUNT;
              sync_lost <= suppress; // [R7]
              synced <= synced & ~suppress; // [R7]
            end
          end
          PIMS_HDR: begin
            sh <= {sh[14:0], bit_in};
            bitcnt <= bitcnt + 5'h01;
            if (bitcnt == `PIMS_HDR_LAST) begin
              bitcnt <= 5'h00;
              if (hdr[11:10] != `PIMS_OP_RD && hdr[11:10] != `PIMS_OP_WR) begin
                state <= PIMS_HUNT;
                sync_lost <= suppress; // [R7]
                synced <= synced & ~suppress; // [R7]
              end else begin
                state <= PIMS_TA;
                is_rd <= (hdr[11:10] == `PIMS_OP_RD);
                own <= (hdr[9:5] == PHY_ADDR);
                req.addr <= hdr[4:0];
                req.rd <= (hdr[11:10] == `PIMS_OP_RD) && (hdr[9:5] == PHY_ADDR);
              end
            end
          end
          PIMS_TA: begin
            bitcnt <= bitcnt + 5'h01;
            if (bitcnt == 5'h00) begin
              sh <= rdata;
              mdio_oe <= is_rd & own;
              mdio_out <= 1'b0;
            end else begin
              state <= PIMS_DATA;
              bitcnt <= 5'h00;
              mdio_out <= sh[15];
              sh <= {sh[14:0], 1'b0};
            end
          end
          PIMS_DATA: begin
            bitcnt <= bitcnt + 5'h01;
            mdio_out <= sh[15];
            sh <= is_rd ? {sh[14:0], 1'b0} : {sh[14:0], bit_in};
            if (bitcnt == `PIMS_DATA_LAST) begin
              state <= PIMS_HUNT;
              ones <= 6'h00;
              mdio_oe <= 1'b0;
              mdio_out <= 1'b1;
              req.wr <= ~is_rd & own;
              req.wdata <= {sh[14:0], bit_in};
            end
          end
        endcase
      end
    end
  end

  // ***************
  // checks
  // ***************
  AST_RESYNC: assert property (@(posedge clk) disable iff (srst) sync_lost |-> !synced) // [R7]
    else $error("still in sync after framing loss");

endmodule : pims_mdio
`default_nettype wire

// file: design/pims_top.sv
// Purpose: interrupt mask, latched interrupt status and upper phy status
// Assumes: event, fault and control inputs come from logic on I_REF_CLK
// Notes: registers are reached through the serial management pins
`timescale 1ns/100ps
`default_nettype none
`include "pims_regs.svh"

//
// Contract
// [R1] Mask register has enables in bits 10..1, resets to zero, bits 15..11 reserved.
// [R2] Mask bit 0 enables the interrupt pin and resets to zero.
// [R3] The pin is low when the pending bit and pin enable are both one, else high. The code also drives it low while the force control is set.
// [R4] Status bits 9..1 latch on their events and hold until cleared.
// [R5] Status bit 10 latches when a cable test or phone detection completes.
// [R6] Status bit 0 latches when an enabled event occurs and resets to zero.
// [R7] With preamble suppression a lost framing sets bit 9 and a full preamble resyncs.
// [R8] The controller should answer a sync loss with one frame carrying a full preamble.
// [R9] Condition bit 15 reads one while in standby, zero otherwise.
// [R10] Clearing link allow enters standby; setting it leaves standby and starts negotiation.
// [R11] Condition bits 14..13 report the negotiation fault code, reset 00. The code shows fault code 11 as 00.
// [R12] Condition bit 12 reads one once negotiation has completed, reset zero. The code shows it only while link allow is set.
// [R13] With link allow clear the link is dropped and partner link pulses ignored.
// [R14] The force control asserts the interrupt pin while set.
// [R15] Reading the status register returns it and clears bits whose event is gone.
module pims_top
  import pims_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input wire logic I_REF_CLK,           // 40 MHz block clock
  input wire logic I_SRST,              // sync reset, high
  input wire logic I_MDC,               // management clock pin
  input wire logic I_MDIO,              // management data pin in
  output logic O_MDIO,                  // management data pin out
  output logic O_MDIO_OE,               // management data pin enable
  input wire logic I_PREAMBLE_SUPPRESS, // preamble suppression control
  input wire logic I_LINK_ALLOW_CTL,    // link allow control
  input wire logic I_FORCE_IRQ,         // force interrupt control
  input wire logic [10:1] I_EVENTS,     // event sources, bit 9 or'd with sync loss
  input wire logic [1:0] I_AN_FAULT,    // negotiation fault code
  input wire logic I_AN_DONE,           // negotiation complete
  input wire logic I_LINK_PULSE,        // partner link pulse seen
  output logic O_LINK_PULSE_OK,         // link pulse accepted
  output logic O_LINK_PERMIT,           // link may stay up
  output logic O_AN_START,              // one-cycle start of negotiation
  output logic O_MGMT_IRQ_PIN_N         // interrupt pin, active low
);

  pims_req_s req;
  logic sync_lost, link_allow_q;
  logic [15:0] mask, stat, rdata;
  logic [10:1] ev_now;
  logic standby, an_done;
  logic [1:0] an_fault;
  logic stat_rd;

  // register access decode, shared by registers and checks
  function automatic logic is_reg_read(input pims_req_s r, input logic [4:0] ofs);
    return r.rd && r.addr == ofs;
  endfunction : is_reg_read

  function automatic logic is_reg_write(input pims_req_s r, input logic [4:0] ofs);
    return r.wr && r.addr == ofs;
  endfunction : is_reg_write

  assign stat_rd = is_reg_read(req, `PIMS_OFS_STAT); // [R15]

  // ***************
  // serial management engine
  // ***************
  pims_mdio #(
    .PHY_ADDR(PHY_ADDR)
  ) u_mdio (
    .clk(I_REF_CLK),
    .srst(I_SRST),
    .mdc_raw(I_MDC),
    .mdio_raw(I_MDIO),
    .suppress(I_PREAMBLE_SUPPRESS),
    .rdata(rdata),
    .req(req),
    .mdio_out(O_MDIO),
    .mdio_oe(O_MDIO_OE),
    .sync_lost(sync_lost)
  );

  always_comb begin
    ev_now = I_EVENTS;
    ev_now[`PIMS_BIT_SYNC_LOST] = I_EVENTS[`PIMS_BIT_SYNC_LOST] | sync_lost; // [R7]
  end

  // ***************
  // mask register
  // ***************
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      mask <= `PIMS_RST_MASK; // [R1] [R2]
    end else if (is_reg_write(req, `PIMS_OFS_MASK)) begin
      mask <= {5'h00, req.wdata[10:0]}; // [R1]
    end
  end

  // ***************
  // latched status, set wins over read clear
  // ***************
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      stat <= `PIMS_RST_STAT; // [R6]
    end else begin
      if (stat_rd) begin
        stat <= 16'h0000; // [R15]
      end
      stat[`PIMS_EV_MSB:`PIMS_EV_LSB] <= ev_now |
        (stat_rd ? 10'h000 : stat[10:1]); // [R4] [R5]
      stat[`PIMS_BIT_PEND] <= (|(ev_now & mask[10:1])) |
        (stat[`PIMS_BIT_PEND] & ~stat_rd); // [R6] [R15]
    end
  end

  // ***************
  // condition report, standby and link
  // ***************
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      standby <= 1'b0;
      an_fault <= `PIMS_RST_FAULT;
      an_done <= 1'b0;
      link_allow_q <= 1'b0;
      O_AN_START <= 1'b0;
      O_LINK_PERMIT <= 1'b0;
      O_LINK_PULSE_OK <= 1'b0;
    end else begin
      link_allow_q <= I_LINK_ALLOW_CTL;
      standby <= ~I_LINK_ALLOW_CTL; // [R9] [R10]
      an_fault <= (I_AN_FAULT == 2'h3) ? `PIMS_RST_FAULT : I_AN_FAULT; // [R11]
      an_done <= I_AN_DONE & I_LINK_ALLOW_CTL; // [R12]
      O_AN_START <= I_LINK_ALLOW_CTL & ~link_allow_q; // [R10]
      O_LINK_PERMIT <= I_LINK_ALLOW_CTL; // [R13]
      O_LINK_PULSE_OK <= I_LINK_PULSE & I_LINK_ALLOW_CTL; // [R13]
    end
  end

  // ***************
  // read data capture
  // ***************
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      rdata <= 16'h0000;
    end else if (req.rd) begin
      unique case (req.addr)
        `PIMS_OFS_MASK: rdata <= mask;
        `PIMS_OFS_STAT: rdata <= stat; // [R15]
        `PIMS_OFS_COND: rdata <= {standby, an_fault, an_done, 12'h000}; // [R9] [R11] [R12]
        default: rdata <= 16'h0000;
      endcase
    end
  end

  // ***************
  // interrupt pin
  // ***************
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      O_MGMT_IRQ_PIN_N <= 1'b1;
    end else begin
      O_MGMT_IRQ_PIN_N <= ~((stat[`PIMS_BIT_PEND] & mask[`PIMS_BIT_PIN_EN]) | // [R2] [R3]
        I_FORCE_IRQ); // [R14]
    end
  end

  // ***************
  // checks
  // ***************
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SRST);

  sequence s_mask_write;
    is_reg_write(req, `PIMS_OFS_MASK);
  endsequence

  sequence s_latch_rise;
    $rose(stat[2]) && !stat_rd;
  endsequence

  sequence s_no_read_2;
    !stat_rd [*2];
  endsequence

  AST_MASK_RESERVED: assert property (mask[15:11] == 5'h00) // [R1]
    else $error("reserved mask bits set");
  AST_MASK_WRITE: assert property (s_mask_write |=> mask[10:0] == $past(req.wdata[10:0])) // [R1]
    else $error("mask write lost");
  AST_PIN_LOW: assert property (stat[0] && mask[0] |=> !O_MGMT_IRQ_PIN_N) // [R3]
    else $error("pin not asserted while pending");
  AST_PIN_GATED: assert property (!mask[0] && !I_FORCE_IRQ |=> O_MGMT_IRQ_PIN_N) // [R2]
    else $error("pin asserted while disabled");
  AST_FORCE: assert property (I_FORCE_IRQ |=> !O_MGMT_IRQ_PIN_N) // [R14]
    else $error("force did not assert pin");
  AST_STICKY: assert property (s_latch_rise ##1 s_no_read_2 |=> stat[2]) // [R4]
    else $error("latched bit dropped without read");
  AST_CABLE_DONE: assert property (I_EVENTS[10] |=> stat[10]) // [R5]
    else $error("completion not latched");
  AST_PEND_SET: assert property (|(ev_now & mask[10:1]) |=> stat[0]) // [R6]
    else $error("pending not set");
  AST_SYNC_LOST: assert property (sync_lost |=> stat[9]) // [R7]
    else $error("sync loss not flagged");
  AST_STANDBY: assert property (!I_LINK_ALLOW_CTL |=> standby && !O_LINK_PERMIT) // [R9] [R13]
    else $error("standby not entered");
  AST_AN_START: assert property ($rose(I_LINK_ALLOW_CTL) |=> O_AN_START ##1 !O_AN_START) // [R10]
    else $error("negotiation start not pulsed");
  AST_FAULT: assert property (I_AN_FAULT != 2'h3 |=> an_fault == $past(I_AN_FAULT)) // [R11]
    else $error("fault code mismatch");
  AST_AN_DONE: assert property (I_AN_DONE && I_LINK_ALLOW_CTL |=> an_done) // [R12]
    else $error("negotiation done not shown");
  AST_READ_CLEAR: assert property (stat_rd && ev_now == 10'h000 |=> stat == 16'h0000) // [R15]
    else $error("read did not clear");
  AST_PIN_RELEASE: assert property (!stat[0] && !I_FORCE_IRQ |=> O_MGMT_IRQ_PIN_N) // [R3]
    else $error("pin asserted with nothing pending");
  AST_PEND_HOLD: assert property (stat[0] && !stat_rd |=> stat[0]) // [R6]
    else $error("pending dropped without read");
  AST_PULSE_GATED: assert property (!I_LINK_ALLOW_CTL |=> !O_LINK_PULSE_OK) // [R13]
    else $error("link pulse passed while not allowed");
  AST_STAT_RESERVED: assert property (stat[15:11] == 5'h00) // [R4]
    else $error("reserved status bits set");
  AST_RD_MASK: assert property (is_reg_read(req, `PIMS_OFS_MASK) |=> rdata == $past(mask)) // [R1]
    else $error("mask read data wrong");

endmodule : pims_top
`default_nettype wire

// file: bench/pims_mgmt_model.sv
// Purpose: management controller model driving serial frames
// Assumes: clock stands low between frames, data line pulled up
// Notes: every edge is taken on the block clock, 8 clocks a bit
`timescale 1ns/100ps
`default_nettype none

module pims_mgmt_model (
  input wire logic i_clk,  // block clock
  input wire logic i_mdio, // resolved data line
  output logic o_mdc,      // management clock
  output logic o_mdio,     // data out
  output logic o_oe        // data enable
);
  initial begin
    o_mdc = 1'b0;
    o_mdio = 1'b1;
    o_oe = 1'b0;
  end

  // one bit: change after the fall, sample at the rise
  task automatic bit_cyc(input logic drv, input logic val, output logic smp);
    o_oe <= drv;
    o_mdio <= val;
    repeat (4) @(posedge i_clk);
    o_mdc <= 1'b1;
    smp = i_mdio;
    repeat (4) @(posedge i_clk);
    o_mdc <= 1'b0;
  endtask : bit_cyc

  // whole frame; a read releases the line from turnaround on
  task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [63:0] w;
    logic s;
    int i;
    w = {32'hffff_ffff, 2'h1, op, phy, ra, 2'h2, wd};
    rd = 16'h0000;
    for (i = pre ? 63 : 31; i >= 0; i--) begin
      bit_cyc(!(op == 2'h2 && i < 18), w[i], s);
      if (i < 16) rd[i] = s;
    end
    o_oe <= 1'b0;
    @(posedge i_clk);
  endtask : frame
endmodule : pims_mgmt_model
`default_nettype wire

// file: bench/pims_top_bench.sv
// Purpose: self-checking bench of the mask and status block
// Assumes: one controller model on the management pins
// Notes: integer model of mask, latch and pin
`timescale 1ns/100ps
`default_nettype none
`include "pims_regs.svh"

module pims_top_bench;
  localparam logic [4:0] phy = 5'h01;
  logic clk, srst, sup, allow, force_irq, pulse, done, mdc, m_out, m_oe, line;
  logic mdio_o, mdio_oe, pulse_ok, permit, an_start, irq_n;
  logic [10:1] ev;
  logic [1:0] fault;
  logic [31:0] lfsr;
  int failures, samples_checked, mask_m, stat_m, n;

  // line pulled up when nobody drives
  assign line = mdio_oe ? mdio_o : (m_oe ? m_out : 1'b1);

  pims_top #(.PHY_ADDR(phy)) pims_top_inst (
    .I_REF_CLK(clk), .I_SRST(srst), .I_MDC(mdc), .I_MDIO(line), .O_MDIO(mdio_o),
    .O_MDIO_OE(mdio_oe), .I_PREAMBLE_SUPPRESS(sup), .I_LINK_ALLOW_CTL(allow),
    .I_FORCE_IRQ(force_irq), .I_EVENTS(ev), .I_AN_FAULT(fault), .I_AN_DONE(done),
    .I_LINK_PULSE(pulse), .O_LINK_PULSE_OK(pulse_ok), .O_LINK_PERMIT(permit),
    .O_AN_START(an_start), .O_MGMT_IRQ_PIN_N(irq_n));

  pims_mgmt_model pims_mgmt_model_inst (
    .i_clk(clk), .i_mdio(line), .o_mdc(mdc), .o_mdio(m_out), .o_oe(m_oe));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // model latch: events set their bit, masked ones the pending bit
  always @(posedge clk) begin
    if (!srst) begin
      stat_m |= {ev, 1'b0};
      if (({ev, 1'b0} & mask_m & 32'h0000_07fe) != 0) stat_m |= 1;
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  function automatic logic pin_exp();
    return !(force_irq || (stat_m[0] && mask_m[0]));
  endfunction : pin_exp

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: word %h, want %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_level(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: level %b, want %b", $time, got, exp);
    end
  endtask : check_level

  task automatic wr_reg(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    pims_mgmt_model_inst.frame(1'b1, `PIMS_OP_WR, phy, ra, d, x);
    if (ra == `PIMS_OFS_MASK) mask_m = d & 16'h07ff;
  endtask : wr_reg

  // read with full preamble; a status read clears what is not held
  task automatic rd_reg(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] d;
    pims_mgmt_model_inst.frame(1'b1, `PIMS_OP_RD, phy, ra, 16'h0000, d);
    check_word(d, exp);
    if (ra == `PIMS_OFS_STAT) begin
      stat_m = {ev, 1'b0};
      if ((stat_m & mask_m & 32'h0000_07fe) != 0) stat_m |= 1;
    end
  endtask : rd_reg

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    {srst, sup, allow, force_irq, pulse, done} = 6'h28;
    ev = '0;
    fault = 2'h0;
    lfsr = 32'h740c_548f;
    {failures, samples_checked, mask_m, stat_m} = '0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    check_level(irq_n, 1'b1);
    for (n = 0; n < 4; n++) begin
      rd_reg(`PIMS_OFS_MASK + n[4:0], 16'h0000);
    end
    wr_reg(`PIMS_OFS_MASK, 16'hffff);
    rd_reg(`PIMS_OFS_MASK, 16'h07ff);
    for (n = 1; n <= 10; n++) begin
      lfsr = lfsr_next(lfsr);
      wr_reg(`PIMS_OFS_MASK, {5'h00, lfsr[10:1], n[0]});
      ev[n] <= 1'b1;
      @(posedge clk);
      ev[n] <= 1'b0;
      repeat (3) @(posedge clk);
      check_level(irq_n, pin_exp());
      rd_reg(`PIMS_OFS_STAT, stat_m[15:0]);
      check_level(irq_n, pin_exp());
      rd_reg(`PIMS_OFS_STAT, stat_m[15:0]);
    end
    wr_reg(`PIMS_OFS_MASK, 16'h0005);
    ev[2] <= 1'b1;
    repeat (3) @(posedge clk);
    check_level(irq_n, 1'b0);
    rd_reg(`PIMS_OFS_STAT, stat_m[15:0]);
    ev[2] <= 1'b0;
    rd_reg(`PIMS_OFS_STAT, stat_m[15:0]);
    rd_reg(`PIMS_OFS_STAT, stat_m[15:0]);
    force_irq <= 1'b1;
    repeat (2) @(posedge clk);
    check_level(irq_n, 1'b0);
    force_irq <= 1'b0;
    repeat (2) @(posedge clk);
    check_level(irq_n, 1'b1);
    for (n = 0; n < 4; n++) begin
      fault <= n[1:0];
      done <= 1'b1;
      repeat (2) @(posedge clk);
      rd_reg(`PIMS_OFS_COND, {1'b0, (n == 3) ? 2'h0 : n[1:0], 13'h1000});
    end
    fault <= 2'h0;
    allow <= 1'b0;
    pulse <= 1'b1;
    repeat (2) @(posedge clk);
    rd_reg(`PIMS_OFS_COND, 16'h8000);
    check_level(pulse_ok | permit, 1'b0);
    allow <= 1'b1;
    repeat (2) @(posedge clk);
    check_level(an_start & permit & pulse_ok, 1'b1);
    @(posedge clk);
    check_level(an_start, 1'b0);
    pulse <= 1'b0;
    rd_reg(`PIMS_OFS_COND, 16'h1000);
    wr_reg(`PIMS_OFS_MASK, 16'h0201);
    sup <= 1'b1;
    pims_mgmt_model_inst.frame(1'b0, 2'h0, phy, `PIMS_OFS_MASK, 16'h0000, lfsr[15:0]);
    repeat (4) @(posedge clk);
    stat_m |= 32'h0000_0201;
    check_level(irq_n, 1'b0);
    rd_reg(`PIMS_OFS_STAT, 16'h0201);
    pims_mgmt_model_inst.frame(1'b0, `PIMS_OP_RD, phy, `PIMS_OFS_MASK, 16'h0000, lfsr[15:0]);
    check_word(lfsr[15:0], 16'h0201);
    sup <= 1'b0;
    tally_and_finish();
  end
endmodule : pims_top_bench
`default_nettype wire
